/* spts_pkg.sv */
// Shared constants, mode codes and decode for the sync pin timing selector
package spts_pkg;

   // Clock and internal oscillator rates
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned OSC_HZ = 32768;
   // Oscillator period in reference clocks, rounded down
   localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;

   // Pin-function field
   localparam int CODE_W = 4;
   localparam logic [3:0] CODE_INTERNAL = 4'h0;
   localparam logic [3:0] CODE_EXT_CLK_MUX = 4'h1;
   localparam logic [3:0] CODE_SLV_SAMPLE = 4'h2;
   localparam logic [3:0] CODE_SLV_SAMPLE_EXT = 4'h3;
   localparam logic [3:0] CODE_MST_SAMPLE = 4'h4;
   localparam logic [3:0] CODE_MST_SAMPLE_EXT = 4'h5;
   localparam logic [3:0] CODE_SLV_EXPO = 4'h6;
   localparam logic [3:0] CODE_MST_EXPO = 4'h7;
   localparam logic [3:0] CODE_MST_EXPO_EXT = 4'h8;
   localparam logic [3:0] CODE_HW_RESYNC = 4'h9;

   typedef enum logic [3:0] {
      MODE_INTERNAL,
      MODE_EXT_CLK_MUX,
      MODE_SLV_SAMPLE,
      MODE_SLV_SAMPLE_EXT,
      MODE_MST_SAMPLE,
      MODE_MST_SAMPLE_EXT,
      MODE_SLV_EXPO,
      MODE_MST_EXPO,
      MODE_MST_EXPO_EXT,
      MODE_HW_RESYNC
   } spts_mode_e;

   // Reserved codes fall back to the power-on behaviour
   function automatic spts_mode_e spts_decode(input logic [3:0] code);
      spts_mode_e m;
      m = MODE_INTERNAL;
      case (code)
         CODE_INTERNAL: m = MODE_INTERNAL;
         CODE_EXT_CLK_MUX: m = MODE_EXT_CLK_MUX;
         CODE_SLV_SAMPLE: m = MODE_SLV_SAMPLE;
         CODE_SLV_SAMPLE_EXT: m = MODE_SLV_SAMPLE_EXT;
         CODE_MST_SAMPLE: m = MODE_MST_SAMPLE;
         CODE_MST_SAMPLE_EXT: m = MODE_MST_SAMPLE_EXT;
         CODE_SLV_EXPO: m = MODE_SLV_EXPO;
         CODE_MST_EXPO: m = MODE_MST_EXPO;
         CODE_MST_EXPO_EXT: m = MODE_MST_EXPO_EXT;
         CODE_HW_RESYNC: m = MODE_HW_RESYNC;
         default: m = MODE_INTERNAL;
      endcase
      return m;
   endfunction

endpackage

/* spts_edge_if.sv */
// Pin levels and their edge pulses shared between top and edge detector
`timescale 1ns/1ps
interface spts_edge_if;
   logic pin_one;
   logic pin_two;
   logic one_rise;
   logic one_fall;
   logic two_rise;

   modport det
   (
      input pin_one,
      input pin_two,
      output one_rise,
      output one_fall,
      output two_rise
   );

   modport user
   (
      output pin_one,
      output pin_two,
      input one_rise,
      input one_fall,
      input two_rise
   );
endinterface

/* spts_edge_det.sv */
// Registered edge detector for both sync pins
`timescale 1ns/1ps
module spts_edge_det
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Pins in, edges out
   spts_edge_if.det edge_io
);

   typedef struct packed {
      logic primed;
      logic one_prev;
      logic two_prev;
      logic one_rise;
      logic one_fall;
      logic two_rise;
   } spts_edge_s;

   spts_edge_s st_q;
   spts_edge_s st_d;

   // No edge on the first sample after reset, so a pin idling high is no rise
   always_comb
   begin
      st_d = st_q;
      st_d.primed = 1'b1;
      st_d.one_prev = edge_io.pin_one;
      st_d.two_prev = edge_io.pin_two;
      st_d.one_rise = st_q.primed & edge_io.pin_one & ~st_q.one_prev;
      st_d.one_fall = st_q.primed & ~edge_io.pin_one & st_q.one_prev;
      st_d.two_rise = st_q.primed & edge_io.pin_two & ~st_q.two_prev;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign edge_io.one_rise = st_q.one_rise;
   assign edge_io.one_fall = st_q.one_fall;
   assign edge_io.two_rise = st_q.two_rise;

endmodule // spts_edge_det

/* spts_sync_pin_timing_select.sv */
// Sync pin role selection and sample / exposure timing source
`timescale 1ns/1ps
module spts_sync_pin_timing_select
#(
   parameter int unsigned OSC_DIV = spts_pkg::OSC_DIV
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Configuration
   input wire logic [3:0] pin_function_code,
   input wire logic software_resync_write,
   input wire logic mux_seq_enable,
   // Sequencer status and requests
   input wire logic local_sample_req,
   input wire logic sample_active,
   input wire logic exposure_active,
   input wire logic exposure_led_456,
   // Sync pin one
   input wire logic sync_pin_one_in,
   output logic sync_pin_one_out,
   output logic sync_pin_one_oe,
   // Sync pin two
   input wire logic sync_pin_two_in,
   output logic sync_pin_two_out,
   output logic sync_pin_two_oe,
   // Timing toward the sequencer
   output logic sample_start,
   output logic sample_abort,
   output logic exposure_tick,
   output logic software_resync_bit
);

   localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;

   typedef struct packed {
      logic [DIV_W-1:0] div_cnt;
      logic osc_tick;
      logic hold;
      logic pin1_out;
      logic pin1_oe;
      logic pin2_out;
      logic pin2_oe;
      logic start;
      logic abort;
      logic tick;
      logic resync_bit;
   } spts_state_s;

   spts_state_s st_q;
   spts_state_s st_d;
   spts_pkg::spts_mode_e mode;
   logic ext_clk;
   logic pin2_mux;

   spts_edge_if e_if ();

   assign e_if.pin_one = sync_pin_one_in;
   assign e_if.pin_two = sync_pin_two_in;

   spts_edge_det u_edge
   (
      .ref_clk (ref_clk),
      .rst_b (rst_b),
      .edge_io (e_if.det)
   );

   assign mode = spts_pkg::spts_decode(pin_function_code);

   always_comb
   begin
      st_d = st_q;
      ext_clk = 1'b0;
      pin2_mux = 1'b0;
      // Internal 32768 Hz oscillator as a one-cycle enable
      if (st_q.div_cnt == DIV_W'(OSC_DIV - 1))
      begin
         st_d.div_cnt = '0;
         st_d.osc_tick = 1'b1;
      end
      else
      begin
         st_d.div_cnt = st_q.div_cnt + 1'b1;
         st_d.osc_tick = 1'b0;
      end
      st_d.pin1_out = 1'b0;
      st_d.pin1_oe = 1'b0;
      st_d.start = local_sample_req;
      st_d.abort = 1'b0;
      unique case (mode)
         spts_pkg::MODE_INTERNAL, spts_pkg::MODE_EXT_CLK_MUX:
         begin
            // Mux control only while a mux state is in the sequence
            st_d.pin1_oe = mux_seq_enable;
            st_d.pin1_out = ~exposure_led_456;
            ext_clk = (mode == spts_pkg::MODE_EXT_CLK_MUX);
         end
         spts_pkg::MODE_SLV_SAMPLE:
         begin
            st_d.start = e_if.one_rise;
            pin2_mux = 1'b1;
         end
         spts_pkg::MODE_SLV_SAMPLE_EXT:
         begin
            st_d.start = e_if.one_rise;
            ext_clk = 1'b1;
         end
         spts_pkg::MODE_MST_SAMPLE, spts_pkg::MODE_MST_SAMPLE_EXT:
         begin
            st_d.pin1_oe = 1'b1;
            st_d.pin1_out = sample_active;
            pin2_mux = (mode == spts_pkg::MODE_MST_SAMPLE);
            ext_clk = (mode == spts_pkg::MODE_MST_SAMPLE_EXT);
         end
         spts_pkg::MODE_SLV_EXPO:
         begin
            st_d.start = e_if.one_rise;
            pin2_mux = 1'b1;
         end
         spts_pkg::MODE_MST_EXPO, spts_pkg::MODE_MST_EXPO_EXT:
         begin
            st_d.pin1_oe = 1'b1;
            st_d.pin1_out = exposure_active;
            pin2_mux = (mode == spts_pkg::MODE_MST_EXPO);
            ext_clk = (mode == spts_pkg::MODE_MST_EXPO_EXT);
         end
         spts_pkg::MODE_HW_RESYNC:
         begin
            ext_clk = 1'b1;
            // Held samples restart only on a pin two rising edge or a software resync
            st_d.start = st_q.hold ? e_if.two_rise : local_sample_req;
         end
      endcase
      // Exposure timebase source; pin two stays an input when not mux control
      if (mode == spts_pkg::MODE_SLV_EXPO)
         st_d.tick = e_if.one_rise;
      else if (ext_clk)
         st_d.tick = e_if.two_rise;
      else
         st_d.tick = st_q.osc_tick;
      st_d.pin2_oe = pin2_mux & mux_seq_enable;
      st_d.pin2_out = pin2_mux & ~exposure_led_456;
      if (mode != spts_pkg::MODE_HW_RESYNC || e_if.two_rise)
         st_d.hold = 1'b0;
      // Software resync overrides any pending start or hold
      if (software_resync_write)
      begin
         st_d.abort = 1'b1;
         st_d.start = 1'b1;
         st_d.hold = 1'b0;
      end
      // A falling edge wins over a same-cycle restart or software resync
      if (mode == spts_pkg::MODE_HW_RESYNC && e_if.one_fall)
      begin
         st_d.hold = 1'b1;
         st_d.abort = 1'b1;
         st_d.start = 1'b0;
      end
      st_d.resync_bit = software_resync_write;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign sync_pin_one_out = st_q.pin1_out;
   assign sync_pin_one_oe = st_q.pin1_oe;
   assign sync_pin_two_out = st_q.pin2_out;
   assign sync_pin_two_oe = st_q.pin2_oe;
   assign sample_start = st_q.start;
   assign sample_abort = st_q.abort;
   assign exposure_tick = st_q.tick;
   assign software_resync_bit = st_q.resync_bit;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   property p_mux_low;
      (mode == spts_pkg::MODE_INTERNAL && mux_seq_enable)
         |=> (sync_pin_one_oe && sync_pin_one_out == !$past(exposure_led_456));
   endproperty
   a_mux_low: assert property (p_mux_low) else $error("pin one mux level wrong");

   property p_mux_tristate;
      (mode == spts_pkg::MODE_INTERNAL && !mux_seq_enable) |=> !sync_pin_one_oe;
   endproperty
   a_mux_tristate: assert property (p_mux_tristate) else $error("pin one driven");

   property p_internal;
      mode == spts_pkg::MODE_INTERNAL
         |=> (!sync_pin_two_oe && exposure_tick == $past(st_q.osc_tick));
   endproperty
   a_internal: assert property (p_internal) else $error("internal timing wrong");

   property p_slave_sample;
      (mode == spts_pkg::MODE_SLV_SAMPLE && !software_resync_write)
         |=> (sample_start == $past(e_if.one_rise) && exposure_tick == $past(st_q.osc_tick));
   endproperty
   a_slave_sample: assert property (p_slave_sample) else $error("slave sample wrong");

   property p_ext_clock;
      (mode == spts_pkg::MODE_SLV_SAMPLE_EXT || mode == spts_pkg::MODE_MST_SAMPLE_EXT)
         |=> (exposure_tick == $past(e_if.two_rise) && !sync_pin_two_oe);
   endproperty
   a_ext_clock: assert property (p_ext_clock) else $error("pin two clock unused");

   property p_master_sample;
      (mode == spts_pkg::MODE_MST_SAMPLE || mode == spts_pkg::MODE_MST_SAMPLE_EXT)
         |=> (sync_pin_one_oe && sync_pin_one_out == $past(sample_active));
   endproperty
   a_master_sample: assert property (p_master_sample) else $error("sample out wrong");

   property p_slave_expo;
      mode == spts_pkg::MODE_SLV_EXPO |=> exposure_tick == $past(e_if.one_rise);
   endproperty
   a_slave_expo: assert property (p_slave_expo) else $error("exposure trigger lost");

   property p_master_expo;
      (mode == spts_pkg::MODE_MST_EXPO || mode == spts_pkg::MODE_MST_EXPO_EXT)
         |=> (sync_pin_one_oe && sync_pin_one_out == $past(exposure_active));
   endproperty
   a_master_expo: assert property (p_master_expo) else $error("exposure out wrong");

   sequence s_hw_fall;
      mode == spts_pkg::MODE_HW_RESYNC && e_if.one_fall;
   endsequence

   sequence s_hw_restart;
      mode == spts_pkg::MODE_HW_RESYNC && e_if.two_rise && !e_if.one_fall;
   endsequence

   property p_hw_abort;
      s_hw_fall |=> (sample_abort && !sample_start);
   endproperty
   a_hw_abort: assert property (p_hw_abort) else $error("resync fall ignored");

   property p_hw_restart;
      st_q.hold ##0 s_hw_restart |=> sample_start;
   endproperty
   a_hw_restart: assert property (p_hw_restart) else $error("no restart on clock");

   property p_sw_resync;
      (software_resync_write && !(mode == spts_pkg::MODE_HW_RESYNC && e_if.one_fall))
         |=> (sample_abort && sample_start && software_resync_bit);
   endproperty
   a_sw_resync: assert property (p_sw_resync) else $error("software resync lost");

   property p_sw_clear;
      !software_resync_write |=> !software_resync_bit;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("resync bit stuck");

   property p_reserved;
      pin_function_code > spts_pkg::CODE_HW_RESYNC |-> mode == spts_pkg::MODE_INTERNAL;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code not default");

endmodule // spts_sync_pin_timing_select

/* spts_far_side_model.sv */
// Far-side model: paired sensor or external trigger and clock source
`timescale 1ns/1ps
module spts_far_side_model
(
   // Clock
   input wire logic ref_clk,
   // Commands from the bench
   input wire logic one_en,
   input wire logic one_lvl,
   input wire logic two_en,
   input wire logic two_lvl,
   input wire logic clk_en,
   // Device side of the pins
   input wire logic dut_one_out,
   input wire logic dut_one_oe,
   input wire logic dut_two_out,
   input wire logic dut_two_oe,
   // Resolved pin levels
   output logic pin_one,
   output logic pin_two
);
   // Paired unit is set up like the device, on the same scheme, and first
   localparam bit PAIR_MATCHED = 1'b1;
   logic div_q;
   logic clk_q;
   logic two_src;
   logic two_val;

   // Clock runs only while enabled, fast so it cannot pass for the oscillator
   always @(negedge ref_clk)
   begin
      div_q <= clk_en ? ~div_q : 1'b0;
      clk_q <= clk_en ? clk_q ^ div_q : 1'b0;
   end

   // Both lines pulled up when released; a clash shows as unknown
   assign two_src = clk_en | two_en;
   assign two_val = clk_en ? clk_q : two_lvl;
   assign pin_one = (one_en & dut_one_oe) ? 1'bx : one_en ? one_lvl :
                    dut_one_oe ? dut_one_out : 1'b1;
   assign pin_two = (two_src & dut_two_oe) ? 1'bx : two_src ? two_val :
                    dut_two_oe ? dut_two_out : 1'b1;
endmodule // spts_far_side_model

/* spts_sync_pin_timing_select_tb.sv */
// Self-checking bench for the sync pin timing selector
`timescale 1ns/1ps
module spts_sync_pin_timing_select_tb;
   localparam int unsigned DIV = 8;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] code = 4'h0;
   logic sw_wr = 1'b0, mux_en = 1'b0, req = 1'b0, sa = 1'b0, ea = 1'b0, led = 1'b0;
   logic p1e = 1'b0, p1l = 1'b0, p2e = 1'b0, p2l = 1'b0, ck = 1'b0;
   logic pin_one, pin_two, one_out, one_oe, two_out, two_oe;
   logic start, abort, tick, rbit, prev_two;
   logic [3:0] exp;
   int n_fail = 0, checks = 0, n_start = 0, n_tick = 0, n_rise = 0, cyc = 0;

   always #2.5 ref_clk = ~ref_clk;

   spts_sync_pin_timing_select #(.OSC_DIV(DIV)) i_spts_sync_pin_timing_select
   (
      .ref_clk(ref_clk), .rst_b(rst_b), .pin_function_code(code),
      .software_resync_write(sw_wr), .mux_seq_enable(mux_en), .local_sample_req(req),
      .sample_active(sa), .exposure_active(ea), .exposure_led_456(led),
      .sync_pin_one_in(pin_one), .sync_pin_one_out(one_out), .sync_pin_one_oe(one_oe),
      .sync_pin_two_in(pin_two), .sync_pin_two_out(two_out), .sync_pin_two_oe(two_oe),
      .sample_start(start), .sample_abort(abort), .exposure_tick(tick),
      .software_resync_bit(rbit)
   );

   spts_far_side_model i_spts_far_side_model
   (
      .ref_clk(ref_clk), .one_en(p1e), .one_lvl(p1l), .two_en(p2e), .two_lvl(p2l),
      .clk_en(ck), .dut_one_out(one_out), .dut_one_oe(one_oe), .dut_two_out(two_out),
      .dut_two_oe(two_oe), .pin_one(pin_one), .pin_two(pin_two)
   );

   task automatic stop_test;
      if (n_fail == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Pulse counters and a hang limit well above the expected run
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      prev_two <= pin_two;
      if (start === 1'b1)
         n_start <= n_start + 1;
      if (tick === 1'b1)
         n_tick <= n_tick + 1;
      if (pin_two === 1'b1 && prev_two === 1'b0)
         n_rise <= n_rise + 1;
   end

   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic chk_bit(input logic e, input logic got);
      checks++;
      if (got !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
      end
   endtask

   task automatic chk_cnt(input int e, input int got);
      checks++;
      if (got != e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
      end
   endtask

   // Expected {one_oe, one_out, two_oe, two_out}; pin two stays off in 0000
   function automatic logic [3:0] roles(input logic [3:0] c, input logic m,
                                        input logic l, input logic s, input logic e);
      logic [1:0] one;
      logic [1:0] two;
      one = 2'b00;
      two = 2'b00;
      if (c == 4'h0 || c == 4'h1 || c >= 4'ha)
         one = {m, ~l};
      if (c == 4'h4 || c == 4'h5)
         one = {1'b1, s};
      if (c == 4'h7 || c == 4'h8)
         one = {1'b1, e};
      if (c == 4'h2 || c == 4'h4 || c == 4'h6 || c == 4'h7)
         two = {m, ~l};
      return {one, two};
   endfunction

   // Trigger slave: a pin one rise starts a sample two cycles on
   task automatic trig(input logic [3:0] c);
      code = c;
      p1e = 1'b1;
      p1l = 1'b0;
      step(4);
      p1l = 1'b1;
      step(1);
      chk_bit(1'b0, start);
      step(1);
      chk_bit(1'b1, start);
      step(1);
      chk_bit(1'b0, start);
      p1e = 1'b0;
      step(1);
   endtask

   // Pin two clock runs in every case, so internal modes must ignore it
   task automatic ticks(input logic [3:0] c, input logic ext);
      int t0;
      int r0;
      int t32;
      code = c;
      step(16);
      t0 = n_tick;
      r0 = n_rise;
      ck = 1'b1;
      step(32);
      t32 = n_tick - t0;
      ck = 1'b0;
      step(4);
      if (ext)
         chk_cnt(n_rise - r0, n_tick - t0);
      else
         chk_cnt(32 / DIV, t32);
   endtask

   // Tests race the hang limit; whichever ends first leads to the one verdict
   initial
   begin
      fork
         begin
            int base;
            step(10);
            chk_bit(1'b0, one_oe);
            chk_bit(1'b0, two_oe);
            rst_b = 1'b1;
            step(2);
            for (int c = 0; c < 16; c++)
               for (int v = 0; v < 4; v++)
               begin
                  code = 4'(c);
                  mux_en = v[0];
                  led = v[1];
                  sa = v[1];
                  ea = v[0] ^ v[1];
                  step(2);
                  exp = roles(code, mux_en, led, sa, ea);
                  chk_bit(exp[3], one_oe);
                  chk_bit(exp[2], one_out);
                  chk_bit(exp[1], two_oe);
                  chk_bit(exp[0], two_out);
               end
            mux_en = 1'b0;
            step(2);
            trig(4'h2);
            trig(4'h3);
            ticks(4'h0, 1'b0);
            ticks(4'h1, 1'b1);
            ticks(4'h2, 1'b0);
            ticks(4'h3, 1'b1);
            ticks(4'h4, 1'b0);
            ticks(4'h5, 1'b1);
            ticks(4'h7, 1'b0);
            ticks(4'h8, 1'b1);
            ticks(4'h9, 1'b1);
            ticks(4'hc, 1'b0);
            // Exposure slave: each pin one rise is one tick, oscillator silent
            code = 4'h6;
            p1e = 1'b1;
            p1l = 1'b0;
            step(8);
            base = n_tick;
            repeat (3)
            begin
               p1l = 1'b1;
               step(3);
               p1l = 1'b0;
               step(3);
            end
            step(2);
            chk_cnt(3, n_tick - base);
            // Resync input: fall aborts and holds, pin two rise restarts
            code = 4'h9;
            p1l = 1'b1;
            p2e = 1'b1;
            p2l = 1'b0;
            step(4);
            base = n_start;
            p1l = 1'b0;
            step(2);
            chk_bit(1'b1, abort);
            chk_bit(1'b0, start);
            step(1);
            chk_bit(1'b0, abort);
            req = 1'b1;
            step(1);
            req = 1'b0;
            step(4);
            chk_cnt(0, n_start - base);
            p2l = 1'b1;
            step(2);
            chk_bit(1'b1, start);
            step(1);
            chk_bit(1'b0, start);
            // Hold released: a local request starts a sample again
            req = 1'b1;
            step(1);
            req = 1'b0;
            chk_bit(1'b1, start);
            // Software resync: one-cycle abort, start and readback
            code = 4'h0;
            p1e = 1'b0;
            p2e = 1'b0;
            step(4);
            sw_wr = 1'b1;
            step(1);
            sw_wr = 1'b0;
            chk_bit(1'b1, abort);
            chk_bit(1'b1, start);
            chk_bit(1'b1, rbit);
            step(1);
            chk_bit(1'b0, abort);
            chk_bit(1'b0, start);
            chk_bit(1'b0, rbit);
         end
         begin
            wait (cyc == 5000);
            n_fail++;
         end
      join_any
      stop_test();
   end
endmodule // spts_sync_pin_timing_select_tb
